/* inc/tc8_cfg.svh */
`ifndef TC8_CFG_SVH
`define TC8_CFG_SVH

// Counter extremes
`define TC8_BOTTOM 8'h00
`define TC8_MAX 8'hFF

// Reset values
`define TC8_CNT_RST 8'h00
`define TC8_CMP_RST 8'h00

// Clock source select codes
`define TC8_CS_STOP 3'h0
`define TC8_CS_DIV1 3'h1
`define TC8_CS_DIV8 3'h2
`define TC8_CS_DIV64 3'h3
`define TC8_CS_DIV256 3'h4
`define TC8_CS_DIV1024 3'h5
`define TC8_CS_EXT_FALL 3'h6
`define TC8_CS_EXT_RISE 3'h7

// Prescaler tap widths (divide by two to the power given)
`define TC8_PRE_W 10
`define TC8_SH_DIV8 3
`define TC8_SH_DIV64 6
`define TC8_SH_DIV256 8
`define TC8_SH_DIV1024 10

// Compare output action codes
`define TC8_ACT_NONE 2'h0
`define TC8_ACT_TOGGLE 2'h1
`define TC8_ACT_CLEAR 2'h2
`define TC8_ACT_SET 2'h3

`endif

/* inc/tc8_pkg.sv */
package tc8_pkg;

  // Wave modes in select-field order
  typedef enum logic [1:0] {
    TC8_NORMAL,
    TC8_PWM_PHASE,
    TC8_CLEAR_ON_MATCH,
    TC8_PWM_FAST
  } tc8_mode_t;

  // Tick generator state
  typedef struct packed {
    logic [9:0] pre;
    logic [2:0] sync;
    logic lvl;
    logic tick;
  } tc8_tick_st_t;

  // Timer core state
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] ocr;
    logic [7:0] ocr_buf;
    logic down;
    logic blk;
    logic ovf_f;
    logic cmp_f;
    logic oc;
    logic ovf_irq;
    logic cmp_irq;
  } tc8_st_t;

endpackage

/* logic/tc8_tick.sv */
`timescale 1ns/100ps
`include "tc8_cfg.svh"

module tc8_tick #(
  parameter int PRE_W = `TC8_PRE_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] clock_source_select,
  input wire logic ext_count_pin,
  output logic timer_tick
);

  tc8_pkg::tc8_tick_st_t st_q;
  tc8_pkg::tc8_tick_st_t st_d;
  logic ext_rise;
  logic ext_fall;

  // Prescaler tap is due when its low bits are all ones
  function automatic logic tap(input logic [9:0] pre, input int sh);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 10; i++) begin
      if (i < sh && !pre[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.pre = st_q.pre + 10'h001;
    st_d.sync = {st_q.sync[1:0], ext_count_pin};
    ext_rise = 1'b0;
    ext_fall = 1'b0;
    // A pin change counts once two later stages agree
    if (st_q.sync[1] == st_q.sync[2] && st_q.sync[2] != st_q.lvl) begin
      st_d.lvl = st_q.sync[2];
      ext_rise = st_q.sync[2];
      ext_fall = !st_q.sync[2];
    end
    case (clock_source_select)
      `TC8_CS_STOP: st_d.tick = 1'b0;
      `TC8_CS_DIV1: st_d.tick = 1'b1;
      `TC8_CS_DIV8: st_d.tick = tap(st_q.pre, `TC8_SH_DIV8);
      `TC8_CS_DIV64: st_d.tick = tap(st_q.pre, `TC8_SH_DIV64);
      `TC8_CS_DIV256: st_d.tick = tap(st_q.pre, `TC8_SH_DIV256);
      `TC8_CS_DIV1024: st_d.tick = tap(st_q.pre, `TC8_SH_DIV1024);
      `TC8_CS_EXT_FALL: st_d.tick = ext_fall;
      `TC8_CS_EXT_RISE: st_d.tick = ext_rise;
      default: st_d.tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign timer_tick = st_q.tick;

endmodule

/* logic/tc8_timer.sv */
// Notes on behaviour
// - Counter and compare value are 8-bit, software readable and writable.
// - Counter 0x00 is bottom, 0xFF is maximum.
// - Top is 0xFF or the compare value, chosen by mode.
// - Tick comes from prescaler or external pin; select 0 stops counting.
// - Each tick clears, increments or decrements the counter per mode.
// - Software may access the counter at any time.
// - Software counter write beats clear or count.
// - Two wave mode bits pick the counting sequence.
// - Overflow flag set at the mode's point and can request interrupt.
// - Counter and compare value compared continuously; equality is a match.
// - Compare flag sets on the tick following the match.
// - Compare interrupt needs its enable and the global flag; sources masked apart.
// - Compare flag clears on service or software write of one.
// - Output formed from match, mode, action bits, max and bottom.
// - PWM modes write compare value to a buffer, others directly.
// - Buffered compare value copied only at top or bottom.
// - Force strobe in non-PWM modes acts on output only.
// - Counter write blocks a match in the next tick cycle.
// - Output state kept across mode changes.
// - Action bits take effect immediately, not buffered.
// - Normal mode counts up, wraps at 0xFF, flags overflow at zero.
// - Clear-on-match mode clears counter on match; compare value is top.
// - Action 0 leaves output unchanged on match in all modes.
// - Reset clears the output state to 0.
`timescale 1ns/100ps
`include "tc8_cfg.svh"

module tc8_timer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ext_count_pin,
  input wire logic [2:0] clock_source_select,
  input wire logic [1:0] wave_mode_select,
  input wire logic [1:0] compare_output_action,
  input wire logic cnt_wr,
  input wire logic [7:0] cnt_wr_data,
  input wire logic cmp_wr,
  input wire logic [7:0] cmp_wr_data,
  input wire logic force_compare_strobe,
  input wire logic ovf_flag_clr,
  input wire logic cmp_flag_clr,
  input wire logic ovf_irq_ack,
  input wire logic cmp_irq_ack,
  input wire logic ovf_irq_enable,
  input wire logic compare_irq_enable,
  input wire logic global_irq_enable,
  output logic [7:0] counter_value,
  output logic [7:0] compare_value,
  output logic overflow_flag,
  output logic compare_flag,
  output logic ovf_irq_req,
  output logic cmp_irq_req,
  output logic compare_output
);

  tc8_pkg::tc8_st_t st_q;
  tc8_pkg::tc8_st_t st_d;
  tc8_pkg::tc8_mode_t mode;
  logic timer_tick;
  logic is_pwm;
  logic at_max;
  logic at_bottom;
  logic match_raw;
  logic match;
  logic top_hit;

  tc8_tick u_tick (
    .clk(clk),
    .rstn(rstn),
    .clock_source_select(clock_source_select),
    .ext_count_pin(ext_count_pin),
    .timer_tick(timer_tick)
  );

  // Output state after a non-PWM compare event
  function automatic logic act_non_pwm(input logic [1:0] act, input logic oc);
    logic r;
    r = oc;
    case (act)
      `TC8_ACT_TOGGLE: r = !oc;
      `TC8_ACT_CLEAR: r = 1'b0;
      `TC8_ACT_SET: r = 1'b1;
      default: r = oc;
    endcase
    return r;
  endfunction

  // Output level for PWM, inverted by action code set
  function automatic logic pwm_level(input logic [1:0] act, input logic lvl, input logic oc);
    logic r;
    r = oc;
    if (act == `TC8_ACT_CLEAR) begin
      r = lvl;
    end else if (act == `TC8_ACT_SET) begin
      r = !lvl;
    end
    return r;
  endfunction

  assign mode = tc8_pkg::tc8_mode_t'(wave_mode_select);
  assign is_pwm = (mode == tc8_pkg::TC8_PWM_PHASE) || (mode == tc8_pkg::TC8_PWM_FAST);
  assign at_max = (st_q.cnt == `TC8_MAX);
  assign at_bottom = (st_q.cnt == `TC8_BOTTOM);
  assign match_raw = (st_q.cnt == st_q.ocr);
  assign match = match_raw && !st_q.blk;
  // top is compare value or maximum
  assign top_hit = (mode == tc8_pkg::TC8_CLEAR_ON_MATCH) ? match : at_max;

  always_comb begin
    st_d = st_q;
    // Overflow event only, merged with the held flag below
    st_d.ovf_f = 1'b0;
    if (timer_tick) begin
      // block pending ends after a tick
      st_d.blk = 1'b0;
      case (mode)
        tc8_pkg::TC8_NORMAL: begin
          st_d.cnt = st_q.cnt + 8'h01;
          if (at_max) begin
            st_d.ovf_f = 1'b1;
          end
        end
        tc8_pkg::TC8_CLEAR_ON_MATCH: begin
          if (top_hit) begin
            st_d.cnt = `TC8_BOTTOM;
          end else begin
            st_d.cnt = st_q.cnt + 8'h01;
          end
          if (at_max) begin
            st_d.ovf_f = 1'b1;
          end
        end
        tc8_pkg::TC8_PWM_FAST: begin
          st_d.cnt = st_q.cnt + 8'h01;
          if (top_hit) begin
            st_d.ovf_f = 1'b1;
            st_d.ocr = st_q.ocr_buf;
            st_d.oc = pwm_level(compare_output_action, 1'b1, st_q.oc);
          end
        end
        tc8_pkg::TC8_PWM_PHASE: begin
          if (at_max) begin
            st_d.down = 1'b1;
            st_d.cnt = st_q.cnt - 8'h01;
            st_d.ocr = st_q.ocr_buf;
          end else if (at_bottom && st_q.down) begin
            st_d.down = 1'b0;
            st_d.cnt = st_q.cnt + 8'h01;
            st_d.ovf_f = 1'b1;
          end else if (st_q.down) begin
            st_d.cnt = st_q.cnt - 8'h01;
          end else begin
            st_d.cnt = st_q.cnt + 8'h01;
          end
        end
        default: st_d.cnt = st_q.cnt;
      endcase
      if (match) begin
        // flag on the tick after match
        st_d.cmp_f = 1'b1;
        if (!is_pwm) begin
          st_d.oc = act_non_pwm(compare_output_action, st_q.oc);
        end else if (mode == tc8_pkg::TC8_PWM_FAST) begin
          if (!at_max) begin
            st_d.oc = pwm_level(compare_output_action, 1'b0, st_q.oc);
          end
        end else begin
          st_d.oc = pwm_level(compare_output_action, st_q.down, st_q.oc);
        end
      end
    end
    if (force_compare_strobe && !is_pwm) begin
      st_d.oc = act_non_pwm(compare_output_action, st_q.oc);
    end
    if (cmp_wr) begin
      st_d.ocr_buf = cmp_wr_data;
      if (!is_pwm) begin
        st_d.ocr = cmp_wr_data;
      end
    end
    if (cnt_wr) begin
      st_d.cnt = cnt_wr_data;
      st_d.blk = 1'b1;
    end
    if ((cmp_flag_clr || cmp_irq_ack) && !(timer_tick && match)) begin
      st_d.cmp_f = 1'b0;
    end
    st_d.ovf_f = st_d.ovf_f || (st_q.ovf_f && !(ovf_flag_clr || ovf_irq_ack));
    st_d.cmp_irq = st_d.cmp_f && compare_irq_enable && global_irq_enable;
    st_d.ovf_irq = st_d.ovf_f && ovf_irq_enable && global_irq_enable;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
      st_q.cnt <= `TC8_CNT_RST;
      st_q.ocr <= `TC8_CMP_RST;
      st_q.ocr_buf <= `TC8_CMP_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign counter_value = st_q.cnt;
  assign compare_value = st_q.ocr;
  assign overflow_flag = st_q.ovf_f;
  assign compare_flag = st_q.cmp_f;
  assign ovf_irq_req = st_q.ovf_irq;
  assign cmp_irq_req = st_q.cmp_irq;
  assign compare_output = st_q.oc;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_cnt_wr;
    cnt_wr |=> counter_value == $past(cnt_wr_data);
  endproperty
  a_cnt_wr: assert property (p_cnt_wr)
    else $error("Counter write lost");

  property p_stop;
    ($past(clock_source_select) == `TC8_CS_STOP && clock_source_select == `TC8_CS_STOP
      && !cnt_wr) |=> $stable(counter_value);
  endproperty
  a_stop: assert property (p_stop)
    else $error("Counter moved while stopped");

  property p_ovf_normal;
    (timer_tick && mode == tc8_pkg::TC8_NORMAL && at_max && !cnt_wr && !ovf_flag_clr
      && !ovf_irq_ack) |=> overflow_flag && counter_value == `TC8_BOTTOM;
  endproperty
  a_ovf_normal: assert property (p_ovf_normal)
    else $error("Normal mode wrap without overflow");

  property p_ctc_clear;
    (timer_tick && mode == tc8_pkg::TC8_CLEAR_ON_MATCH && match && !cnt_wr)
      |=> counter_value == `TC8_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear)
    else $error("Match did not clear counter");

  property p_cmp_flag;
    (timer_tick && match) |=> compare_flag;
  endproperty
  a_cmp_flag: assert property (p_cmp_flag)
    else $error("Compare flag not set after match");

  property p_block;
    (timer_tick && st_q.blk && !compare_flag) |=> !compare_flag;
  endproperty
  a_block: assert property (p_block)
    else $error("Match not blocked after counter write");

  property p_blk_set;
    cnt_wr |=> st_q.blk;
  endproperty
  a_blk_set: assert property (p_blk_set)
    else $error("Counter write did not arm the block");

  property p_irq;
    cmp_irq_req |-> compare_flag && $past(compare_irq_enable) && $past(global_irq_enable);
  endproperty
  a_irq: assert property (p_irq)
    else $error("Compare interrupt without enable");

  property p_flag_clr;
    (cmp_flag_clr && !(timer_tick && match)) |=> !compare_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("Compare flag not cleared");

  property p_pwm_buf;
    (cmp_wr && mode == tc8_pkg::TC8_PWM_FAST && !(timer_tick && at_max))
      |=> compare_value == $past(compare_value);
  endproperty
  a_pwm_buf: assert property (p_pwm_buf)
    else $error("PWM compare write not buffered");

  property p_force;
    (force_compare_strobe && !is_pwm && !(timer_tick && match)) |=>
      (($past(compare_output_action) == `TC8_ACT_TOGGLE) && !$stable(compare_output))
      || (($past(compare_output_action) == `TC8_ACT_CLEAR) && !compare_output)
      || (($past(compare_output_action) == `TC8_ACT_SET) && compare_output)
      || (($past(compare_output_action) == `TC8_ACT_NONE) && $stable(compare_output));
  endproperty
  a_force: assert property (p_force)
    else $error("Force strobe did not act on output");

  property p_ovf_wins;
    (timer_tick && mode == tc8_pkg::TC8_NORMAL && at_max) |=> overflow_flag;
  endproperty
  a_ovf_wins: assert property (p_ovf_wins)
    else $error("Overflow lost to a same-cycle clear");

  property p_pwm_copy;
    (timer_tick && mode == tc8_pkg::TC8_PWM_FAST && at_max)
      |=> compare_value == $past(st_q.ocr_buf);
  endproperty
  a_pwm_copy: assert property (p_pwm_copy)
    else $error("Buffered compare value not copied at top");

  property p_oc_keep;
    (!timer_tick && !force_compare_strobe) |=> $stable(compare_output);
  endproperty
  a_oc_keep: assert property (p_oc_keep)
    else $error("Output state moved without an event");

  c_ovf: cover property (timer_tick && mode == tc8_pkg::TC8_NORMAL && at_max);
  c_force: cover property (force_compare_strobe && !is_pwm);
  c_ctc: cover property (timer_tick && mode == tc8_pkg::TC8_CLEAR_ON_MATCH && match);
  c_buf: cover property (timer_tick && is_pwm && at_max && st_q.ocr != st_q.ocr_buf);
  c_phase: cover property (timer_tick && mode == tc8_pkg::TC8_PWM_PHASE && at_bottom && st_q.down);

endmodule

/* sim/tc8_timer_bench.sv */
`timescale 1ns/100ps
`include "tc8_cfg.svh"

module tc8_timer_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ext_pin = 1'b0;
  logic [2:0] css = `TC8_CS_STOP;
  logic [1:0] mode = tc8_pkg::TC8_NORMAL;
  logic [1:0] act = `TC8_ACT_NONE;
  logic cnt_wr = 1'b0;
  logic [7:0] cnt_d = 8'h00;
  logic cmp_wr = 1'b0;
  logic [7:0] cmp_d = 8'h00;
  logic force_s = 1'b0;
  logic ovf_clr = 1'b0;
  logic cmp_clr = 1'b0;
  logic ovf_ack = 1'b0;
  logic cmp_ack = 1'b0;
  logic ovf_en = 1'b0;
  logic cmp_en = 1'b0;
  logic gie = 1'b0;
  logic [7:0] cnt;
  logic [7:0] cmp;
  logic ovf_f;
  logic cmp_f;
  logic ovf_irq;
  logic cmp_irq;
  logic oc;
  int n_fail = 0;
  int n_tests = 0;

  tc8_timer i_dut (
    .clk(clk),
    .rstn(rstn),
    .ext_count_pin(ext_pin),
    .clock_source_select(css),
    .wave_mode_select(mode),
    .compare_output_action(act),
    .cnt_wr(cnt_wr),
    .cnt_wr_data(cnt_d),
    .cmp_wr(cmp_wr),
    .cmp_wr_data(cmp_d),
    .force_compare_strobe(force_s),
    .ovf_flag_clr(ovf_clr),
    .cmp_flag_clr(cmp_clr),
    .ovf_irq_ack(ovf_ack),
    .cmp_irq_ack(cmp_ack),
    .ovf_irq_enable(ovf_en),
    .compare_irq_enable(cmp_en),
    .global_irq_enable(gie),
    .counter_value(cnt),
    .compare_value(cmp),
    .overflow_flag(ovf_f),
    .compare_flag(cmp_f),
    .ovf_irq_req(ovf_irq),
    .cmp_irq_req(cmp_irq),
    .compare_output(oc)
  );

  always #5 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Strobe selectors for pulse
  localparam int S_CNT_WR = 0;
  localparam int S_CMP_WR = 1;
  localparam int S_FORCE = 2;
  localparam int S_OVF_CLR = 3;
  localparam int S_CMP_CLR = 4;
  localparam int S_CMP_ACK = 5;
  localparam int S_OVF_ACK = 6;

  task automatic set_strobe(input int sel, input logic v);
    case (sel)
      S_CNT_WR: cnt_wr = v;
      S_CMP_WR: cmp_wr = v;
      S_FORCE: force_s = v;
      S_OVF_CLR: ovf_clr = v;
      S_CMP_CLR: cmp_clr = v;
      S_CMP_ACK: cmp_ack = v;
      default: ovf_ack = v;
    endcase
  endtask

  // One-cycle strobe, then a spare cycle so strobes never abut
  task automatic pulse(input int sel);
    set_strobe(sel, 1'b1);
    @(negedge clk);
    set_strobe(sel, 1'b0);
    @(negedge clk);
  endtask

  task automatic wr_cnt(input logic [7:0] d);
    cnt_d = d;
    pulse(S_CNT_WR);
  endtask

  task automatic wr_cmp(input logic [7:0] d);
    cmp_d = d;
    pulse(S_CMP_WR);
  endtask

  // Tick every cycle for k counts, then stop and let it settle
  task automatic run(input int k);
    css = `TC8_CS_DIV1;
    cyc(k);
    css = `TC8_CS_STOP;
    cyc(2);
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic done(input string nm);
    $display("End of test %s, mismatches so far %0d", nm, n_fail);
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    cyc(1);
    chk("counter", 8'h00, cnt);
    chk("compare", 8'h00, cmp);
    chk("output", 8'h00, oc);
    chk("flags", 8'h00, {ovf_f, cmp_f, ovf_irq, cmp_irq});
    done("reset");
    ovf_en = 1'b1;
    cmp_en = 1'b1;
    gie = 1'b1;
    act = `TC8_ACT_TOGGLE;
    wr_cnt(8'hFE);
    run(2);
    chk("counter wrap", 8'h00, cnt);
    chk("overflow", 8'h01, ovf_f);
    chk("ovf irq", 8'h01, ovf_irq);
    chk("cmp flag", 8'h00, cmp_f);
    pulse(S_OVF_CLR);
    cyc(1);
    chk("overflow clr", 8'h00, ovf_f);
    done("normal wrap");
    wr_cmp(8'h10);
    chk("compare direct", 8'h10, cmp);
    wr_cnt(8'h0E);
    run(2);
    chk("cmp flag early", 8'h00, cmp_f);
    run(1);
    chk("counter", 8'h11, cnt);
    chk("cmp flag", 8'h01, cmp_f);
    chk("toggle", 8'h01, oc);
    chk("cmp irq", 8'h01, cmp_irq);
    gie = 1'b0;
    cyc(2);
    chk("irq global off", 8'h00, cmp_irq);
    gie = 1'b1;
    cmp_en = 1'b0;
    cyc(2);
    chk("irq masked", 8'h00, cmp_irq);
    cmp_en = 1'b1;
    cyc(2);
    chk("irq unmasked", 8'h01, cmp_irq);
    pulse(S_CMP_ACK);
    cyc(1);
    chk("cmp flag ack", 8'h00, cmp_f);
    chk("cmp irq ack", 8'h00, cmp_irq);
    done("compare");
    wr_cnt(8'h10);
    run(1);
    chk("counter", 8'h11, cnt);
    chk("blocked flag", 8'h00, cmp_f);
    chk("blocked out", 8'h01, oc);
    done("blocking");
    css = `TC8_CS_DIV1;
    cyc(3);
    cnt_d = 8'h40;
    cnt_wr = 1'b1;
    css = `TC8_CS_STOP;
    cyc(1);
    cnt_wr = 1'b0;
    cyc(2);
    chk("write priority", 8'h40, cnt);
    done("priority");
    act = `TC8_ACT_CLEAR;
    pulse(S_FORCE);
    chk("force clear", 8'h00, oc);
    act = `TC8_ACT_SET;
    pulse(S_FORCE);
    chk("force set", 8'h01, oc);
    chk("force flag", 8'h00, cmp_f);
    chk("force counter", 8'h40, cnt);
    act = `TC8_ACT_NONE;
    wr_cnt(8'h0F);
    run(2);
    chk("match flag", 8'h01, cmp_f);
    chk("no action", 8'h01, oc);
    pulse(S_CMP_CLR);
    chk("cmp flag clr", 8'h00, cmp_f);
    done("force");
    mode = tc8_pkg::TC8_CLEAR_ON_MATCH;
    wr_cmp(8'h05);
    wr_cnt(8'h03);
    run(3);
    chk("clear on match", 8'h00, cnt);
    chk("no overflow", 8'h00, ovf_f);
    pulse(S_CMP_CLR);
    done("clear on match");
    mode = tc8_pkg::TC8_PWM_FAST;
    cyc(1);
    chk("mode change out", 8'h01, oc);
    wr_cmp(8'h80);
    chk("buffered", 8'h05, cmp);
    wr_cnt(8'hFD);
    run(3);
    chk("counter", 8'h00, cnt);
    chk("copy at top", 8'h80, cmp);
    chk("pwm overflow", 8'h01, ovf_f);
    act = `TC8_ACT_CLEAR;
    pulse(S_FORCE);
    chk("force ignored", 8'h01, oc);
    act = `TC8_ACT_NONE;
    done("fast pwm");
    mode = tc8_pkg::TC8_PWM_PHASE;
    wr_cnt(8'hFE);
    run(3);
    chk("turn down", 8'hFD, cnt);
    done("phase pwm");
    mode = tc8_pkg::TC8_NORMAL;
    wr_cnt(8'hFF);
    css = `TC8_CS_DIV1;
    cyc(1);
    ovf_clr = 1'b1;
    css = `TC8_CS_STOP;
    cyc(1);
    ovf_clr = 1'b0;
    cyc(2);
    chk("set beats clear", 8'h01, ovf_f);
    chk("wrap", 8'h00, cnt);
    pulse(S_OVF_ACK);
    chk("overflow ack", 8'h00, ovf_f);
    chk("ovf irq ack", 8'h00, ovf_irq);
    done("overflow clear");
    wr_cnt(8'h20);
    css = `TC8_CS_EXT_RISE;
    cyc(8);
    ext_pin = 1'b1;
    cyc(8);
    ext_pin = 1'b0;
    cyc(8);
    css = `TC8_CS_STOP;
    cyc(5);
    chk("ext count", 8'h21, cnt);
    done("external");
    give_verdict();
  end
endmodule
